// ### hw/real_mode_pkg.sv
// Purpose: Shared constants and types of the real-mode address/fault unit
// Assumes: 32-bit APB register bus, byte offsets
// Notes:   All figures of the unit are named here
package real_mode_pkg;

    // ==========
    // Register map (byte offsets)
    localparam logic [11:0] off_idt_limit   = 12'h000;
    localparam logic [11:0] off_status      = 12'h004;
    localparam logic [11:0] off_fault_info  = 12'h008;

    // ==========
    // Reset values and field positions
    localparam logic [15:0] idt_limit_rst   = 16'h03ff;
    localparam int          st_lsb          = 0;
    localparam int          far_done_bit    = 2;
    localparam int          real_mode_bit   = 3;
    localparam int          count_lsb       = 8;

    // ==========
    // Addressing figures
    localparam logic [31:0] seg_last_offset = 32'h0000ffff;
    localparam logic [31:0] phys_max        = 32'h0010ffef;
    localparam int          seg_shift       = 4;
    localparam int          vec_shift       = 2;
    localparam logic [31:0] vec_area_last   = 32'h000003ff;
    localparam logic [17:0] low_line_mask   = 18'h3ffff;
    localparam logic [11:0] high_lines_set  = 12'hfff;
    localparam logic [11:0] high_lines_clr  = 12'h000;

    // ==========
    // Exception vectors raised in this mode
    localparam logic [7:0]  vec_lock        = 8'h06;
    localparam logic [7:0]  vec_limit       = 8'h08;
    localparam logic [7:0]  vec_stack       = 8'h0c;
    localparam logic [7:0]  vec_overrun     = 8'h0d;

    // ==========
    // Shutdown exit thresholds
    localparam logic [15:0] nmi_limit_min   = 16'h0017;
    localparam logic [15:0] nmi_sp_floor    = 16'h0005;

    // ==========
    // Types
    typedef enum logic [1:0]
    {
        st_run      = 2'b00,
        st_halt     = 2'b01,
        st_shutdown = 2'b10
    } cpu_state_e;

    typedef enum logic [1:0]
    {
        kind_code  = 2'b00,
        kind_data  = 2'b01,
        kind_stack = 2'b10
    } access_kind_e;

    typedef enum logic [3:0]
    {
        cls_other   = 4'h0,
        cls_bit_op  = 4'h1,
        cls_exchange_operation    = 4'h2,
        cls_and     = 4'h3,
        cls_sub     = 4'h4,
        cls_xor     = 4'h5,
        cls_not     = 4'h6,
        cls_neg     = 4'h7,
        cls_inc     = 4'h8,
        cls_dec     = 4'h9
    } instr_class_e;

endpackage

// ### hw/real_mode_address_fault_logic.sv
// Purpose: Real-mode address forming, limit checks, lock check, halt and
//          shutdown control, with an APB register file
// Assumes: All request inputs are one-cycle pulses synchronous to clk_sys
// Notes:   Only vectors 6, 8, 12 and 13 can ever be raised here
`timescale 1ns/100ps

module real_mode_address_fault_logic
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory access requests
    input  wire logic        acc_valid,
    input  wire logic [1:0]  acc_kind,
    input  wire logic [15:0] acc_seg,
    input  wire logic [31:0] acc_offset,
    input  wire logic [1:0]  acc_len_m1,
    input  wire logic        acc_push,
    input  wire logic [15:0] stack_pointer,
    input  wire logic        far_transfer,
    // Instruction decode
    input  wire logic        instr_valid,
    input  wire logic [3:0]  instr_class,
    input  wire logic        instr_mem_dest,
    input  wire logic        instr_rep,
    input  wire logic        lock_prefix,
    input  wire logic        size_override,
    // Interrupts and halt
    input  wire logic        int_valid,
    input  wire logic [7:0]  int_vector,
    input  wire logic        halt_instruction,
    input  wire logic        nmi,
    input  wire logic        maskable_interrupt_input,
    input  wire logic        if_flag,
    // Status and results
    output logic             real_mode,
    output logic             paging_enable,
    output logic             op_size_32,
    output logic      [31:0] phys_addr,
    output logic      [29:0] addr_lines,
    output logic             fault_valid,
    output logic      [7:0]  fault_vector,
    output logic             fault_ret_before,
    output logic      [31:0] vector_addr,
    output logic             vector_fetch,
    output logic             halted,
    output logic             shutdown,
    output logic             bus_hold,
    output logic             resume_next
);

    // ==========
    // State
    typedef struct packed
    {
        real_mode_pkg::cpu_state_e st;
        logic                      far_done;
        logic [15:0]               idt_limit;
        logic [7:0]                fault_count;
        logic [7:0]                last_vector;
        logic [31:0]               phys;
        logic [29:0]               lines;
        logic                      fault_valid;
        logic [7:0]                fault_vector;
        logic                      ret_before;
        logic [31:0]               vec_addr;
        logic                      vec_fetch;
        logic                      resume;
        logic                      op32;
        logic [31:0]               prdata;
    } state_s;

    state_s s_q;
    state_s s_d;

    // ==========
    // Functions
    function automatic logic past_limit(input logic [31:0] offs,
                                        input logic [1:0]  len_m1);
        logic [32:0] last;
        last = {1'b0, offs} + {31'h0, len_m1};
        past_limit = last > {1'b0, real_mode_pkg::seg_last_offset};
    endfunction

    function automatic logic vec_beyond(input logic [7:0]  vec,
                                        input logic [15:0] limit);
        logic [17:0] top;
        top = {vec, 2'h3} + 18'h0;
        vec_beyond = top > {2'h0, limit};
    endfunction

    // Mask keeps a fetch inside the vector area
    function automatic logic [31:0] vec_location(input logic [7:0] vec);
        vec_location = {22'h0, vec, 2'h0} & real_mode_pkg::vec_area_last;
    endfunction

    function automatic logic lock_legal(input logic [3:0] cls,
                                        input logic       mem_dest,
                                        input logic       rep);
        logic listed;
        listed = 1'b0;
        case (cls)
            real_mode_pkg::cls_bit_op, real_mode_pkg::cls_exchange_operation,
            real_mode_pkg::cls_and, real_mode_pkg::cls_sub,
            real_mode_pkg::cls_xor, real_mode_pkg::cls_not,
            real_mode_pkg::cls_neg, real_mode_pkg::cls_inc,
            real_mode_pkg::cls_dec:
                listed = 1'b1;
            default:
                listed = 1'b0;
        endcase
        lock_legal = listed && mem_dest && !rep;
    endfunction

    // ==========
    // Bus decode
    logic        setup_phase;
    logic        mapped;
    logic [31:0] phys_calc;
    logic [31:0] status_word;
    logic [31:0] fault_word;
    logic        stack_wrap;
    logic        overrun;
    logic        lock_fault;
    logic [7:0]  raise_vec;
    logic        raise;

    always_comb
    begin
        setup_phase = psel && !penable;
        mapped      = (paddr == real_mode_pkg::off_idt_limit) ||
                      (paddr == real_mode_pkg::off_status)    ||
                      (paddr == real_mode_pkg::off_fault_info);
        // No wait states: every access ends in two cycles, setup and access
        pready      = 1'b1;
        pslverr     = psel && penable && !mapped;
    end

    // ==========
    // Fault detection
    always_comb
    begin
        phys_calc  = {12'h0, acc_seg, 4'h0} + acc_offset;
        overrun    = acc_valid && past_limit(acc_offset, acc_len_m1);
        // An odd pointer below the push size wraps mid-word
        stack_wrap = acc_valid && acc_push &&
                     (acc_kind == real_mode_pkg::kind_stack) &&
                     stack_pointer[0] &&
                     (stack_pointer <= {14'h0, acc_len_m1});
        // Privilege level is deliberately not an input here
        lock_fault = instr_valid && lock_prefix &&
                     !lock_legal(instr_class, instr_mem_dest,
                                 instr_rep);
        raise      = 1'b0;
        raise_vec  = real_mode_pkg::vec_overrun;
        if (lock_fault)
        begin
            raise     = 1'b1;
            raise_vec = real_mode_pkg::vec_lock;
        end
        else if (overrun && acc_kind == real_mode_pkg::kind_stack)
        begin
            raise     = 1'b1;
            raise_vec = real_mode_pkg::vec_stack;
        end
        else if (overrun)
        begin
            raise     = 1'b1;
            raise_vec = real_mode_pkg::vec_overrun;
        end
        else if (int_valid && vec_beyond(int_vector, s_q.idt_limit))
        begin
            raise     = 1'b1;
            raise_vec = real_mode_pkg::vec_limit;
        end
    end

    // ==========
    // Register views
    always_comb
    begin
        // Read-only views; writes to them are dropped
        status_word = 32'h0;
        status_word[real_mode_pkg::st_lsb +: 2]    = s_q.st;
        status_word[real_mode_pkg::far_done_bit]   = s_q.far_done;
        status_word[real_mode_pkg::real_mode_bit]  = 1'b1;
        status_word[real_mode_pkg::count_lsb +: 8] = s_q.fault_count;
        fault_word  = {23'h0, s_q.ret_before, s_q.last_vector};
    end

    // ==========
    // Next state
    always_comb
    begin
        s_d             = s_q;
        s_d.fault_valid = 1'b0;
        s_d.vec_fetch   = 1'b0;
        s_d.resume      = 1'b0;
        // Size lags the prefix by one cycle, like the other flops
        s_d.op32        = size_override;

        // Register file
        if (setup_phase)
        begin
            s_d.prdata = 32'h0;
            if (!pwrite && paddr == real_mode_pkg::off_idt_limit)
            begin
                s_d.prdata = {16'h0, s_q.idt_limit};
            end
            else if (!pwrite && paddr == real_mode_pkg::off_status)
            begin
                s_d.prdata = status_word;
            end
            else if (!pwrite && paddr == real_mode_pkg::off_fault_info)
            begin
                s_d.prdata = fault_word;
            end
        end
        if (psel && penable && pwrite &&
            paddr == real_mode_pkg::off_idt_limit)
        begin
            s_d.idt_limit = pwdata[15:0];
        end

        case (s_q.st)
            real_mode_pkg::st_run:
            begin
                if (acc_valid)
                begin
                    s_d.phys = phys_calc;
                    // Upper lines float high on code cycles until a far
                    // transfer, as after reset
                    s_d.lines = {((acc_kind == real_mode_pkg::kind_code) &&
                                  !s_q.far_done) ?
                                 real_mode_pkg::high_lines_set :
                                 real_mode_pkg::high_lines_clr,
                                 phys_calc[19:2] &
                                 real_mode_pkg::low_line_mask};
                end
                if (far_transfer)
                begin
                    s_d.far_done = 1'b1;
                end
                if (stack_wrap)
                begin
                    s_d.st = real_mode_pkg::st_shutdown;
                end
                else if (raise &&
                         (raise_vec == real_mode_pkg::vec_limit ||
                          raise_vec == real_mode_pkg::vec_overrun) &&
                         vec_beyond(raise_vec, s_q.idt_limit))
                begin
                    s_d.st = real_mode_pkg::st_shutdown;
                end
                else if (raise)
                begin
                    // Only 6, 8, 12, 13 reach this point
                    s_d.fault_valid  = 1'b1;
                    s_d.fault_vector = raise_vec;
                    s_d.ret_before   = 1'b1;
                    s_d.last_vector  = raise_vec;
                    s_d.fault_count  = s_q.fault_count + 8'h01;
                    s_d.vec_addr     = vec_location(raise_vec);
                    s_d.vec_fetch    = 1'b1;
                end
                else if (int_valid)
                begin
                    s_d.vec_addr  = vec_location(int_vector);
                    s_d.vec_fetch = 1'b1;
                end
                else if (halt_instruction)
                begin
                    s_d.st = real_mode_pkg::st_halt;
                end
            end
            real_mode_pkg::st_halt:
            begin
                if (nmi || (maskable_interrupt_input && if_flag))
                begin
                    s_d.st         = real_mode_pkg::st_run;
                    s_d.resume     = 1'b1;
                    s_d.ret_before = 1'b0;
                end
            end
            real_mode_pkg::st_shutdown:
            begin
                if (nmi && s_q.idt_limit >= real_mode_pkg::nmi_limit_min &&
                    stack_pointer > real_mode_pkg::nmi_sp_floor)
                begin
                    s_d.st     = real_mode_pkg::st_run;
                    s_d.resume = 1'b1;
                end
            end
            default:
            begin
                s_d.st = real_mode_pkg::st_run;
            end
        endcase
    end

    // ==========
    // State register
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '{st        : real_mode_pkg::st_run,
                     idt_limit : real_mode_pkg::idt_limit_rst,
                     // Every other field starts cleared
                     default   : '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========
    // Outputs
    always_comb
    begin
        real_mode        = 1'b1;
        paging_enable    = 1'b0;
        op_size_32       = s_q.op32;
        phys_addr        = s_q.phys;
        addr_lines       = s_q.lines;
        fault_valid      = s_q.fault_valid;
        fault_vector     = s_q.fault_vector;
        fault_ret_before = s_q.ret_before;
        vector_addr      = s_q.vec_addr;
        vector_fetch     = s_q.vec_fetch;
        halted           = (s_q.st == real_mode_pkg::st_halt);
        shutdown         = (s_q.st == real_mode_pkg::st_shutdown);
        bus_hold         = halted || shutdown;
        resume_next      = s_q.resume;
        prdata           = s_q.prdata;
    end

endmodule

// ### tb/irq_source_model.sv
// Purpose: Interrupt sources on the far side of the unit
// Assumes: One request at a time, lag counted in clocks
// Notes:   Lines idle low; a request gives a one-clock pulse
`timescale 1ns/100ps
module irq_source_model
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Request from the bench
    input  wire logic       fire,
    input  wire logic       fire_nmi,
    input  wire logic [3:0] lag,
    // Interrupt lines
    output logic            nmi,
    output logic            maskable_interrupt_input
);
    // ==========
    // Delay then pulse
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       kind_q;
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {cnt_q, busy_q, kind_q, nmi, maskable_interrupt_input} <= '0;
        else if (fire)
        begin
            {busy_q, kind_q, cnt_q} <= {1'b1, fire_nmi, lag};
            {nmi, maskable_interrupt_input} <= 2'b00;
        end
        else
        begin
            {nmi, maskable_interrupt_input} <=
                {2{busy_q && cnt_q == 4'h0}} & {kind_q, !kind_q};
            busy_q <= busy_q && cnt_q != 4'h0;
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// ### tb/real_mode_address_fault_logic_asserts.sv
// Purpose: Port assertions of the real-mode fault unit
// Assumes: Table limit tracked from APB writes
// Notes:   Ports grouped per line to keep the file short
`timescale 1ns/100ps
module rm_fault_checker
(
    input wire logic clk_sys, reset, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, acc_offset, phys_addr, vector_addr,
    input wire logic acc_valid, acc_push, far_transfer, instr_valid,
    input wire logic [1:0] acc_kind, acc_len_m1,
    input wire logic [15:0] acc_seg, stack_pointer,
    input wire logic [3:0] instr_class,
    input wire logic instr_mem_dest, instr_rep, lock_prefix, size_override,
    input wire logic int_valid, nmi, maskable_interrupt_input, if_flag,
    input wire logic [7:0] int_vector, fault_vector,
    input wire logic real_mode, paging_enable, op_size_32, fault_valid,
    input wire logic [29:0] addr_lines,
    input wire logic fault_ret_before, vector_fetch, halted, shutdown,
    input wire logic bus_hold, resume_next
);
    // ==========
    // Helpers
    logic [15:0] lim_q;
    logic        far_q;
    logic        ovr;
    logic        wrap;
    logic        lock_ok;
    logic        solo;
    logic        vlim;
    logic [31:0] pa_x;
    always_comb
    begin
        ovr = {1'b0, acc_offset} + 33'(acc_len_m1) > 33'h0ffff;
        wrap = acc_push && acc_kind == 2'b10 && stack_pointer[0]
            && stack_pointer <= 16'(acc_len_m1);
        lock_ok = !instr_rep && instr_mem_dest
            && instr_class inside {[4'h1:4'h9]};
        solo = acc_valid && !bus_hold && !instr_valid && !int_valid;
        vlim = {22'h0, int_vector, 2'b11} > {16'h0, lim_q};
        pa_x = {12'h0, acc_seg, 4'h0} + acc_offset;
    end
    // Write effect mirrored so limit-dependent outcomes can be judged
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {lim_q, far_q} <= {real_mode_pkg::idt_limit_rst, 1'b0};
        else
        begin
            if (psel && penable && pwrite
                && paddr == real_mode_pkg::off_idt_limit)
                lim_q <= pwdata[15:0];
            if (far_transfer && !bus_hold)
                far_q <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==========
    // Assertions
    chk_mode_fixed:
    assert property (real_mode && !paging_enable) else $error("mode bad");
    chk_size_follow:
    assert property (1'b1 |=> op_size_32 == $past(size_override))
        else $error("operand size bad");
    chk_addr_form:
    assert property (solo && !ovr |=> phys_addr == $past(pa_x))
        else $error("physical address bad");
    chk_line_map:
    assert property (solo && !ovr |=> addr_lines == {($past(
        acc_kind == 2'b00 && !far_q) ? 12'hfff : 12'h000), phys_addr[19:2]})
        else $error("address lines bad");
    chk_seg_overrun:
    assert property (solo && ovr && acc_kind != 2'b10 |=>
        ($past(lim_q) >= 16'h0037 ? fault_valid && fault_vector == 8'h0d
        && fault_ret_before : shutdown && !fault_valid))
        else $error("segment overrun bad");
    chk_stack_overrun:
    assert property (solo && ovr && acc_kind == 2'b10 && !wrap |=>
        fault_valid && fault_vector == 8'h0c && fault_ret_before)
        else $error("stack overrun bad");
    chk_stack_wrap:
    assert property (solo && wrap |=> shutdown && !fault_valid)
        else $error("stack wrap bad");
    chk_lock_check:
    assert property (!bus_hold && instr_valid && lock_prefix && !acc_valid
        && !int_valid |=> (fault_valid && fault_vector == 8'h06)
        == !$past(lock_ok)) else $error("lock check bad");
    chk_int_limit:
    assert property (!bus_hold && int_valid && !acc_valid && !instr_valid
        |=> ($past(vlim) ? (fault_valid && fault_vector == 8'h08)
        || shutdown : vector_fetch
        && vector_addr == {22'h0, $past(int_vector), 2'b00}))
        else $error("vector bad");
    chk_fault_set:
    assert property (fault_valid |-> fault_vector inside
        {8'h06, 8'h08, 8'h0c, 8'h0d}) else $error("vector not allowed");
    chk_halt_stay:
    assert property (halted && !nmi && !(maskable_interrupt_input
        && if_flag) |=> halted && bus_hold) else $error("halt left");
    chk_halt_exit:
    assert property (halted && (nmi || maskable_interrupt_input && if_flag)
        |=> !halted && resume_next && !fault_ret_before)
        else $error("halt exit bad");
    chk_sd_exit:
    assert property (shutdown && nmi |=> shutdown == ($past(lim_q)
        < 16'h0017 || $past(stack_pointer) <= 16'h0005))
        else $error("shutdown exit bad");
    cover property (fault_valid && fault_vector == 8'h0d);
    cover property (shutdown ##1 !shutdown);
    cover property ($fell(halted) && resume_next);
endmodule

// ### tb/real_mode_address_fault_logic_tb.sv
// Purpose: Self-checking bench of the real-mode fault unit
// Assumes: APB answers through pready; events checked at negedge
// Notes:   Fault, fetch and resume pulses matched to queued notes
`timescale 1ns/100ps
module real_mode_address_fault_logic_tb;
    // ==========
    // Signals
    logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, acc_offset = '0, phys_addr;
    logic [31:0] vector_addr, rd;
    logic pready, pslverr, acc_valid = 0, acc_push = 0, far_transfer = 0;
    logic [1:0] acc_kind = '0, acc_len_m1 = '0;
    logic [15:0] acc_seg = '0, stack_pointer = 16'h0100;
    logic instr_valid = 0, instr_mem_dest = 0, instr_rep = 0;
    logic lock_prefix = 0, size_override = 0, int_valid = 0, if_flag = 0;
    logic halt_instruction = 0, fire = 0, fire_nmi = 0, er, far_seen = 0;
    logic [3:0] instr_class = '0, lag = '0;
    logic [7:0] int_vector = '0, fault_vector;
    logic nmi, maskable_interrupt_input, real_mode, paging_enable;
    logic op_size_32, fault_valid, fault_ret_before, vector_fetch;
    logic halted, shutdown, bus_hold, resume_next;
    logic [29:0] addr_lines;
    logic [39:0] expq[$];
    int n_fail = 0, checks_done = 0;
    real_mode_address_fault_logic real_mode_address_fault_logic_i (.*);
    irq_source_model irq_source_model_i (.*);
    initial forever #5 clk_sys = ~clk_sys;
    // ==========
    // Tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic note(input logic [7:0] v);
        expq.push_back({8'h01, 24'h0, v});
        expq.push_back({8'h02, 22'h0, v, 2'b00});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int i;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (i == 20)
            begin n_fail++; tally_and_finish(); end
    endtask
    task automatic req(input int w);
        @(posedge clk_sys);
        {acc_valid, instr_valid, int_valid, halt_instruction,
            far_transfer} <= 5'b10000 >> w;
        @(posedge clk_sys);
        {acc_valid, instr_valid, int_valid, halt_instruction,
            far_transfer} <= 5'h0;
        @(negedge clk_sys);
    endtask
    task automatic acc(input logic [1:0] k, input logic [15:0] s,
                       input logic [31:0] o, input logic [1:0] l);
        @(posedge clk_sys);
        {acc_kind, acc_seg, acc_offset, acc_len_m1} <= {k, s, o, l};
        req(0);
    endtask
    task automatic acc_ok(input logic [1:0] k, input logic [15:0] s,
                          input logic [31:0] o);
        logic [31:0] pa;
        pa = {12'h0, s, 4'h0} + o;
        acc(k, s, o, 2'd0);
        chk({8'h0, phys_addr}, {8'h0, pa});
        chk({10'h0, addr_lines}, {10'h0, (k == 2'd0 && !far_seen) ?
            12'hfff : 12'h000, pa[19:2]});
    endtask
    task automatic irq(input logic n, input logic [3:0] l);
        @(posedge clk_sys);
        {fire, fire_nmi, lag} <= {1'b1, n, l};
        @(posedge clk_sys);
        fire <= 0;
    endtask
    task automatic wait_free;
        int i;
        for (i = 0; i < 20 && bus_hold !== 1'b0; i++)
            @(negedge clk_sys);
        if (i == 20)
            begin n_fail++; tally_and_finish(); end
    endtask
    task automatic pop(input logic [39:0] got);
        chk(got, expq.size() ? expq.pop_front() : 40'hff);
    endtask
    // ==========
    // Monitor
    always @(negedge clk_sys)
    begin
        if (!reset && fault_valid === 1'b1)
            pop({8'h01, 24'h0, fault_vector});
        if (!reset && vector_fetch === 1'b1 && resume_next !== 1'b1)
            pop({8'h02, vector_addr});
        if (!reset && resume_next === 1'b1)
            pop({8'h03, 32'h0});
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end
    // ==========
    // Scenarios
    initial
    begin
        rd = $urandom(32'h2189d87b);
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        apb(0, 12'h004, 0);
        chk(rd, 32'h8);
        apb(1, 12'h004, -1);
        apb(0, 12'h004, 0);
        chk(rd, 32'h8);
        apb(0, 12'h00c, 0);
        chk({er, rd}, {1'b1, 32'h0});
        @(posedge clk_sys);
        size_override <= 1;
        repeat (2) @(negedge clk_sys);
        chk(op_size_32, 1);
        size_override <= 0;
        $display("registers and mode done");
        acc_ok(0, 16'h1234, 32'h0010);
        far_seen = 1;
        req(4);
        acc_ok(0, 16'h1234, 32'h0010);
        for (int i = 0; i < 8; i++)
            acc_ok(2'($urandom % 2), 16'($urandom), $urandom & 32'hffff);
        acc_ok(1, 16'hffff, 32'hffff);
        $display("addressing done");
        note(8'h0d);
        acc(1, 16'h0100, 32'hffff, 1);
        chk(fault_ret_before, 1);
        note(8'h0d);
        acc(0, 16'h0100, 32'hfffe, 3);
        note(8'h0c);
        acc(2, 16'h0100, 32'hffff, 1);
        acc(1, 16'h0100, 32'hfffe, 1);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_sys);
            instr_class <= (i < 10) ? i[3:0] : 4'h2;
            {instr_rep, instr_mem_dest, lock_prefix} <= {i == 10, i != 11, 1'b1};
            if (i == 0 || i > 9)
                note(8'h06);
            req(1);
        end
        $display("limits and lock done");
        int_vector <= 8'hff;
        expq.push_back({8'h02, 32'h3fc});
        req(2);
        apb(1, 12'h000, 32'h3f);
        int_vector <= 8'h0f;
        expq.push_back({8'h02, 32'h3c});
        req(2);
        int_vector <= 8'h10;
        note(8'h08);
        req(2);
        $display("vectors done");
        req(3);
        chk({halted, bus_hold}, 2'b11);
        acc(1, 16'h0100, 32'hffff, 1);
        irq(0, 0);
        repeat (8) @(negedge clk_sys);
        chk(halted, 1);
        if_flag <= 1;
        expq.push_back({8'h03, 32'h0});
        irq(0, 5);
        wait_free();
        chk(fault_ret_before, 0);
        req(3);
        expq.push_back({8'h03, 32'h0});
        irq(1, 0);
        wait_free();
        $display("halt done");
        apb(1, 12'h000, 32'h30);
        acc(1, 16'h0100, 32'hffff, 1);
        chk(shutdown, 1);
        stack_pointer <= 16'h0004;
        irq(1, 0);
        repeat (8) @(negedge clk_sys);
        chk(shutdown, 1);
        stack_pointer <= 16'h0006;
        expq.push_back({8'h03, 32'h0});
        irq(1, 3);
        wait_free();
        {stack_pointer, acc_push} <= {16'h0001, 1'b1};
        acc(2, 16'h0200, 32'hffff, 1);
        chk(shutdown, 1);
        acc_push <= 0;
        apb(1, 12'h000, 32'h10);
        stack_pointer <= 16'h0006;
        irq(1, 0);
        repeat (8) @(negedge clk_sys);
        chk(shutdown, 1);
        reset <= 1;
        repeat (3) @(posedge clk_sys);
        reset <= 0;
        apb(0, 12'h004, 0);
        chk(rd, 32'h8);
        apb(0, 12'h000, 0);
        chk(rd, 32'h3ff);
        chk(40'(expq.size()), 40'h0);
        $display("shutdown done");
        tally_and_finish();
    end
endmodule

bind real_mode_address_fault_logic rm_fault_checker rm_fault_checker_i (.*);
